// ===== src/adc_serial_readout_control.v
// Conversion control and serial readout of a 16-bit converter.
// Assumes pins arrive asynchronously; the serial clock is sampled by mclk.
`timescale 1ns/1ps
`default_nettype none
`include "adc_readout_defines.vh"
module adc_serial_readout_control #(
  parameter WIDTH = `RESULT_BITS
) (
  input  wire             mclk,
  input  wire             rst,
  input  wire             conversion_start_pin,
  input  wire             daisy_select_input,
  input  wire             serial_clock,
  input  wire             fast_rate_select,
  input  wire [WIDTH-1:0] sample_code,
  input  wire             sample_valid,
  output wire             sample_ready,
  output reg              serial_result_output,
  output reg              serial_result_oe,
  output reg              converting,
  output reg              powered_down,
  output reg              chain_mode,
  output reg              busy_armed,
  output reg              safe_read_passed,
  output reg              result_discard
);
  wire cnv_s;
  wire sdi_s;
  wire sck_s;
  wire trb_s;
  pin_sync u_cnv (.mclk(mclk), .rst(rst), .pin_in(conversion_start_pin), .pin_sync_ff(cnv_s));
  pin_sync u_sdi (.mclk(mclk), .rst(rst), .pin_in(daisy_select_input), .pin_sync_ff(sdi_s));
  pin_sync u_sck (.mclk(mclk), .rst(rst), .pin_in(serial_clock), .pin_sync_ff(sck_s));
  pin_sync u_trb (.mclk(mclk), .rst(rst), .pin_in(fast_rate_select), .pin_sync_ff(trb_s));

  // Delayed copies for edge detection; only synchronised levels are read.
  reg cnv_d_ff;
  reg sdi_d_ff;
  reg sck_d_ff;
  always @(posedge mclk) begin
    if (rst) begin
      cnv_d_ff <= 1'b0;
      sdi_d_ff <= 1'b0; // Same level as the synchroniser after reset, so no false fall.
      sck_d_ff <= 1'b0;
    end else begin
      cnv_d_ff <= cnv_s;
      sdi_d_ff <= sdi_s;
      sck_d_ff <= sck_s;
    end
  end
  wire cnv_rise = cnv_s & ~cnv_d_ff;
  wire cnv_fall = ~cnv_s & cnv_d_ff;
  wire sdi_fall = ~sdi_s & sdi_d_ff;
  wire sdi_rise = sdi_s & ~sdi_d_ff;
  wire sck_fall = ~sck_s & sck_d_ff;
  // Three-wire reads start on the start pin falling; four-wire reads on the
  // daisy input falling while the start pin is held high.
  wire sel_start = cnv_fall | (sdi_fall & cnv_s);

  // Results from the analog core are buffered and taken one per conversion end, so the core stalls once all four buffer entries are full.
  wire             fifo_valid;
  wire [WIDTH-1:0] fifo_data;
  reg              pop;
  result_fifo #(.WIDTH(WIDTH), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   (sample_code),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data)
  );

  reg [1:0]       state_ff;
  reg [1:0]       nxt_state;
  reg [`CNT_W-1:0] timer_ff;
  reg [`CNT_W-1:0] nxt_timer;
  reg             turbo_ff;
  reg             first_ff;
  reg [WIDTH-1:0] shift_ff;
  reg [4:0]       bits_ff;
  reg             sel_ff;
  wire [31:0]       safe_full = turbo_ff ? `SAFE_TURBO_CYC : `SAFE_NORM_CYC;
  wire [`CNT_W-1:0] safe_cyc  = safe_full[`CNT_W-1:0];
  wire conv_end = (state_ff == `ST_CONV) && (timer_ff == `CONV_CYC - 1);

  always @* begin
    nxt_state = state_ff;
    nxt_timer = timer_ff;
    case (state_ff)
      `ST_IDLE, `ST_ACQ: begin
        if (cnv_rise) begin
          nxt_state = `ST_CONV;
          nxt_timer = {`CNT_W{1'b0}};
        end
      end
      `ST_CONV: begin
        nxt_timer = timer_ff + 1'b1;
        if (conv_end) begin
          nxt_state = `ST_ACQ;
        end
      end
      default: begin
        nxt_state = `ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      state_ff         <= `ST_IDLE;
      timer_ff         <= {`CNT_W{1'b0}};
      converting       <= 1'b0;
      powered_down     <= 1'b1;
      chain_mode       <= 1'b0;
      busy_armed       <= 1'b0;
      safe_read_passed <= 1'b0;
      turbo_ff         <= 1'b0;
      first_ff         <= 1'b1;
      result_discard   <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      timer_ff   <= nxt_timer;
      converting <= (nxt_state == `ST_CONV);
      if (cnv_rise && state_ff != `ST_CONV) begin
        // Daisy tied to the start pin still reads low here, so chain wins.
        chain_mode       <= ~sdi_d_ff & ~trb_s;
        turbo_ff         <= trb_s;
        busy_armed       <= 1'b0;
        safe_read_passed <= 1'b0;
        powered_down     <= 1'b0;
      end
      if (state_ff == `ST_CONV && timer_ff == safe_cyc - 1) begin
        safe_read_passed <= 1'b1;
      end
      if (conv_end) begin
        busy_armed     <= ~chain_mode & ~turbo_ff & (~cnv_s | ~sdi_s);
        powered_down   <= ~turbo_ff;
        result_discard <= first_ff & turbo_ff;
        first_ff       <= 1'b0;
      end
      if (cnv_rise && state_ff != `ST_CONV && trb_s && !turbo_ff) begin
        first_ff <= 1'b1;
      end
    end
  end

  // Output side: select tracks the start pin in three-wire use, the daisy
  // input in four-wire use; either falling selects, and the last bit's clock fall deselects.
  always @(posedge mclk) begin
    if (rst) begin
      shift_ff             <= {WIDTH{1'b0}};
      bits_ff              <= 5'h00;
      sel_ff               <= 1'b0;
      serial_result_output <= 1'b0;
      serial_result_oe     <= 1'b0;
      pop                  <= 1'b0;
    end else begin
      pop <= 1'b0;
      if (conv_end) begin
        if (fifo_valid) begin
          shift_ff <= fifo_data;
          pop      <= 1'b1;
        end
        bits_ff <= 5'h00;
        if (~chain_mode & ~turbo_ff & (~cnv_s | ~sdi_s)) begin
          sel_ff               <= 1'b1;
          serial_result_oe     <= 1'b1;
          serial_result_output <= 1'b0;
        end
      end else if (cnv_rise) begin
        sel_ff           <= 1'b0;
        serial_result_oe <= 1'b0;
      end else if (!busy_armed && !sel_ff && sel_start && !converting) begin
        sel_ff               <= 1'b1;
        serial_result_oe     <= 1'b1;
        serial_result_output <= shift_ff[WIDTH-1];
        bits_ff              <= 5'h01;
      end else if (!busy_armed && !sel_ff && sel_start) begin
        sel_ff               <= 1'b1;
        serial_result_oe     <= 1'b1;
        serial_result_output <= shift_ff[WIDTH-1];
        bits_ff              <= 5'h01;
      end else if (busy_armed && sdi_rise && cnv_s) begin
        sel_ff           <= 1'b0;
        serial_result_oe <= 1'b0;
      end else if (sel_ff && sck_fall) begin
        // The count holds the bits shown so far; with busy the start bit
        // counts as none, so the 17th fall releases there and the 16th without.
        if (bits_ff == WIDTH) begin
          sel_ff               <= 1'b0;
          serial_result_oe     <= 1'b0;
          serial_result_output <= 1'b0;
        end else begin
          serial_result_output <= shift_ff[WIDTH-1-bits_ff[3:0]];
          bits_ff              <= bits_ff + 5'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== src/adc_readout_defines.vh
// Constants for the converter readout control block.
// Assumes a 10 MHz system clock; included by the control module only.
`ifndef ADC_READOUT_DEFINES_VH
`define ADC_READOUT_DEFINES_VH
`define CLK_PERIOD_NS      100
`define RESULT_BITS        16
`define SAFE_READ_TURBO_NS 190
`define SAFE_READ_NORM_NS  290
`define CONV_TIME_NS       500
`define SAFE_TURBO_CYC     ((`SAFE_READ_TURBO_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SAFE_NORM_CYC      ((`SAFE_READ_NORM_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CYC           ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FIFO_DEPTH         4
`define FIFO_AW            2
`define CNT_W              8
`define ST_IDLE            2'h0
`define ST_CONV            2'h1
`define ST_ACQ             2'h2
`endif

// ===== src/pin_sync.v
// Two-flop synchroniser for one asynchronous pin.
// Assumes the pin is a slow level relative to the clock.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input  wire mclk,
  input  wire rst,
  input  wire pin_in,
  output reg  pin_sync_ff
);
  reg meta_ff;
  always @(posedge mclk) begin
    if (rst) begin
      meta_ff     <= 1'b0;
      pin_sync_ff <= 1'b0;
    end else begin
      meta_ff     <= pin_in;
      pin_sync_ff <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// ===== src/result_fifo.v
// Small flip-flop FIFO for completed conversion results.
// Assumes one clock; a write while full is held off by in_ready.
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             mclk,
  input  wire             rst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0]    wr_ff;
  reg [AW-1:0]    rd_ff;
  reg [AW:0]      cnt_ff;
  wire            do_wr;
  wire            do_rd;
  assign in_ready  = (cnt_ff != DEPTH[AW:0]);
  assign out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign out_data  = mem_ff[rd_ff];
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;
  always @(posedge mclk) begin
    if (do_wr) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
  always @(posedge mclk) begin
    if (rst) begin
      wr_ff  <= {AW{1'b0}};
      rd_ff  <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (do_rd) begin
        rd_ff <= rd_ff + 1'b1;
      end
      if (do_wr & ~do_rd) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (do_rd & ~do_wr) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/adc_readout_props.sv
// Port checker for the converter readout control block.
// Bound to the top module; pins reach the logic through two-flop synchronisers.
`timescale 1ns/1ps
`default_nettype none
module adc_readout_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic conversion_start_pin,
  input wire logic daisy_select_input,
  input wire logic serial_clock,
  input wire logic fast_rate_select,
  input wire logic serial_result_output,
  input wire logic serial_result_oe,
  input wire logic converting,
  input wire logic powered_down,
  input wire logic chain_mode,
  input wire logic busy_armed,
  input wire logic safe_read_passed,
  input wire logic result_discard
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic [3:0] idle_ff;
  logic [3:0] quiet_ff;
  logic       sck_ff;
  // Counters saturate so that long idle stretches never wrap back to zero.
  always_ff @(posedge mclk) begin
    sck_ff <= serial_clock;
    if (rst || !(conversion_start_pin && daisy_select_input)) idle_ff <= 4'h0;
    else idle_ff <= idle_ff + {3'h0, idle_ff != 4'hF};
    if (rst || serial_clock != sck_ff) quiet_ff <= 4'h0;
    else quiet_ff <= quiet_ff + {3'h0, quiet_ff != 4'hF};
  end
  a_turbo_no_chain: assert property ($past(fast_rate_select, 5) && fast_rate_select
    |-> !$rose(chain_mode)) else $error("chain mode entered in turbo");
  a_turbo_no_busy: assert property ($past(fast_rate_select, 5) && fast_rate_select
    |-> !$rose(busy_armed)) else $error("busy armed in turbo");
  a_conv_length: assert property ($rose(converting)
    |-> converting [*5] ##1 !converting) else $error("conversion length wrong");
  a_safe_read_mark: assert property ($rose(converting)
    |-> ##[1:4] safe_read_passed) else $error("safe-read point not marked");
  a_awake_converting: assert property (converting && $past(converting)
    |-> !powered_down) else $error("asleep during conversion");
  a_sleep_after_norm: assert property ($fell(converting) && !fast_rate_select
    |-> ##[0:2] powered_down) else $error("no power down after conversion");
  a_idle_release: assert property (idle_ff >= 4'h6
    |-> !serial_result_oe) else $error("output driven while deselected");
  // The start bit legitimately replaces the data at conversion end.
  a_sdo_hold: assert property (quiet_ff >= 4'h5 && !$fell(converting)
    && serial_result_oe && $past(serial_result_oe)
    |-> $stable(serial_result_output)) else $error("data moved without clock edge");
  c_busy: cover property ($rose(busy_armed));
  c_chain: cover property ($rose(chain_mode));
  c_discard: cover property ($rose(result_discard));
endmodule
bind adc_serial_readout_control adc_readout_props i_props (.*);
`default_nettype wire

// ===== verification/core_model.sv
// Model of the analog core handing finished codes to the result buffer.
// Assumes one clock; the offered code is held until sample_ready takes it.
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        stall,
  input  wire logic [15:0] code_in,
  input  wire logic        sample_ready,
  output var  logic [15:0] sample_code,
  output var  logic        sample_valid,
  output var  logic        pushed
);
  always_ff @(posedge mclk) begin
    if (rst) begin
      sample_valid <= 1'b0;
      sample_code  <= 16'h0;
    end else if (!sample_valid || sample_ready) begin
      sample_valid <= !stall;
      sample_code  <= code_in;
    end
  end
  assign pushed = sample_valid && sample_ready;
endmodule
`default_nettype wire

// ===== verification/adc_serial_readout_control_test.sv
// Self-checking bench for the readout block acting as host and core source.
// Assumes the checker is bound to the block; the serial clock runs at 800 ns.
`timescale 1ns/1ps
`default_nettype none
module adc_serial_readout_control_test;
  logic        mclk = 0, rst = 1, conversion_start_pin = 0, daisy_select_input = 1;
  logic        serial_clock = 0, fast_rate_select = 0, stall = 0, sample_valid, sample_ready;
  logic        serial_result_output, serial_result_oe, converting, powered_down, pushed;
  logic        chain_mode, busy_armed, safe_read_passed, result_discard;
  logic [15:0] sample_code, code_in = 16'h0, got;
  logic [15:0] exp_q [$];
  int          n_fail = 0, n_tests = 0, cyc = 0;
  event        got_ev;
  adc_serial_readout_control i_dut (.*);
  core_model i_core (.*);
  initial forever #50 mclk = ~mclk;
  initial begin
    void'($urandom(32'hB527));
    forever @(negedge mclk) code_in = 16'($urandom);
  end
  always @(posedge mclk) if (!rst && pushed) exp_q.push_back(sample_code);
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk_bit(input logic a, input logic e, input string m);
    n_tests++;
    if (a !== e) begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic chk_word(input logic [15:0] a, input logic [15:0] e);
    n_tests++;
    if (a !== e) begin
      n_fail++;
      $display("mismatch at %0t: word %h expected %h", $time, a, e);
    end
  endtask
  always @(got_ev) chk_word(got, exp_q.pop_front());
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge mclk) if (++cyc == 4000) begin
    n_fail++;
    wrap_up();
  end
  // A quiet gap precedes each start edge so the strap level is settled when sampled.
  task automatic convert(input logic strap, input logic early_lo);
    conversion_start_pin = 0;
    daisy_select_input = strap;
    tick(4);
    conversion_start_pin = 1;
    tick(4);
    daisy_select_input = 1;
    if (early_lo) conversion_start_pin = 0;
    tick(1);
    chk_bit(converting, 1'b1, "not converting");
    tick(8);
    chk_bit(converting, 1'b0, "conversion overran");
  endtask
  task automatic read(input logic four, input logic busy);
    logic [15:0] w;
    w = 16'h0;
    if (four) daisy_select_input = 0;
    else conversion_start_pin = 0;
    tick(4);
    chk_bit(serial_result_oe, 1'b1, "output not driven");
    for (int i = 0; i < (busy ? 17 : 16); i++) begin
      if (busy && i == 0) chk_bit(serial_result_output, 1'b0, "start bit");
      else w = {w[14:0], serial_result_output};
      serial_clock = 1;
      tick(4);
      serial_clock = 0;
      tick(4);
    end
    got = w;
    ->got_ev;
    chk_bit(serial_result_oe, 1'b0, "output not released");
    daisy_select_input = 1;
  endtask
  initial begin
    tick(4);
    rst = 0;
    tick(8);
    chk_bit(powered_down, 1'b1, "reset power state");
    chk_bit(sample_ready, 1'b0, "buffer did not refuse");
    $display("test reset and fill done");
    stall = 1;
    for (int k = 0; k < 4; k++) begin
      convert(1'b1, k[0]);
      chk_bit(chain_mode, 1'b0, "strap high gave chain");
      chk_bit(busy_armed, k[0], "busy arming");
      chk_bit(powered_down, 1'b1, "no sleep");
      read(k[1] & ~k[0], k[0]);
    end
    chk_bit(sample_ready, 1'b1, "buffer not drained");
    stall = 0;
    $display("test cs reads done");
    convert(1'b0, 1'b0);
    chk_bit(chain_mode, 1'b1, "strap low gave cs");
    void'(exp_q.pop_front());
    conversion_start_pin = 0;
    daisy_select_input = 0;
    tick(4);
    conversion_start_pin = 1;
    daisy_select_input = 1;
    tick(13);
    chk_bit(chain_mode, 1'b1, "tied strap gave cs");
    void'(exp_q.pop_front());
    $display("test chain done");
    fast_rate_select = 1;
    for (int j = 0; j < 2; j++) begin
      convert(1'b0, 1'b0);
      chk_bit(chain_mode, 1'b0, "chain in turbo");
      chk_bit(busy_armed, 1'b0, "busy in turbo");
      chk_bit(result_discard, j == 0, "discard flag");
      // The slow host reads only after conversion ends, so no burst crosses the safe-read point.
      read(1'b0, 1'b0);
    end
    $display("test turbo done");
    wrap_up();
  end
endmodule
`default_nettype wire
